// *** rtl/timer8_pkg.sv ***
// package: register map, fields, timing and carriers of the 8-bit timer
////////////////////////////////////////////////////////////////////////////////
// What this block does
// - timer mode without prescaler: count once per instruction cycle
// - a write to the counter blocks counting for two instruction cycles
// - counter mode counts pin edges; edge select 1 falling, 0 rising
// - rollover from FF to 00 sets the overflow flag
// - interrupt only while enabled; software clears flag, hardware never does
// - the timer stops during sleep, so it never wakes the processor
// - counter mode source is sampled on the second and fourth phase clocks
// - one 8-bit prescaler; assign bit 1 serves watchdog, 0 serves timer
// - rate code: timer 1:2 up to 1:256, watchdog 1:1 up to 1:128
// - prescaler not accessible; counter writes clear it while timer-assigned
// - watchdog clear also clears the prescaler while watchdog-assigned
// - option register resets to all ones
// - option bit 7 drives the global pull-up disable of the first port
// - option bit 6 selects external interrupt edge, 1 rising, 0 falling
// - count pin reads zero on its digital path while analog-selected
package timer8_pkg;
  localparam int ADDR_W = 12;
  localparam logic [7:0] IDX_TIMER_COUNT = 8'h01;
  localparam logic [7:0] IDX_INT_CONTROL = 8'h0B;
  localparam logic [7:0] IDX_OPTION = 8'h81;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h20;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h21;
  localparam logic [7:0] OPTION_RESET = 8'hFF;
  localparam logic [7:0] INTCON_RESET = 8'h00;
  localparam int BIT_PULLUP_DIS = 7;
  localparam int BIT_INT_EDGE = 6;
  localparam int BIT_CLK_SRC = 5;
  localparam int BIT_CNT_EDGE = 4;
  localparam int BIT_PS_ASSIGN = 3;
  localparam int PS_RATE_LSB = 0;
  localparam int BIT_OVF_EN = 5;
  localparam int BIT_OVF_FLAG = 2;
  localparam int EV_OVERFLOW = 0;
  localparam int EV_WDT_TICK = 1;
  localparam int NUM_EVENTS = 2;
  localparam int CLK_PERIOD_NS = 10;
  localparam int INSTR_CYCLE_NS = 40;
  localparam int CLKS_PER_INSTR = INSTR_CYCLE_NS / CLK_PERIOD_NS;
  localparam int INHIBIT_INSTR = 2;
  localparam logic [3:0] INHIBIT_CLKS = 4'(INHIBIT_INSTR * CLKS_PER_INSTR);
  localparam logic [1:0] PHASE_Q2 = 2'h1;
  localparam logic [1:0] PHASE_Q4 = 2'h3;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } apb_rsp_type;

  typedef struct packed {
    logic [1:0] phase;
    logic pin_meta;
    logic pin_sync;
    logic src_prev;
    logic ps_sample;
    logic [7:0] count;
    logic [3:0] inhibit;
    logic [7:0] prescale;
    logic [7:0] option;
    logic [7:0] intcon;
    logic [NUM_EVENTS-1:0] status;
    logic [NUM_EVENTS-1:0] mask;
    apb_rsp_type rsp;
    logic timer_int;
    logic irq;
    logic wdt_tick;
  } timer_state_type;
endpackage : timer8_pkg

// *** rtl/timer8.sv ***
// 8-bit timer/counter with shared prescaler and APB register slave
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
module timer8
  import timer8_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire apb_req_type i_apb,
  output apb_rsp_type o_apb,
  input wire logic i_ext_count_pin,
  input wire logic i_analog_select,
  input wire logic i_sleep,
  input wire logic i_wdt_event,
  input wire logic i_wdt_clear,
  output logic o_wdt_tick,
  output logic o_timer_int,
  output logic o_irq,
  output logic o_port_pullup_disable,
  output logic o_ext_int_edge_rising
);
  timer_state_type st;
  timer_state_type nx;

  logic counter_mode;
  logic to_wdt;
  logic [2:0] rate;
  logic pin_level;
  logic src_level;
  logic instr_tick;
  logic src_event;
  logic ps_event;
  logic [7:0] ps_mask;
  logic wdt_tick_c;
  logic samp_in;
  logic samp_phase;
  logic samp_rise;
  logic inc_req;
  logic inc;
  logic ovf_ev;
  logic setup;
  logic access;
  logic [7:0] idx;
  logic aligned;
  logic wr;
  logic wr_timer;
  logic wr_intcon;
  logic [NUM_EVENTS-1:0] events;
  logic [7:0] rd_data;
  logic rd_hit;

  ////////////////////////////////////////////////////////////////////////////
  // clock source and prescaler
  assign counter_mode = st.option[BIT_CLK_SRC];
  assign to_wdt = st.option[BIT_PS_ASSIGN];
  assign rate = st.option[PS_RATE_LSB+:3];
  assign pin_level = st.pin_sync & ~i_analog_select;
  // inverting the level turns a falling edge into a rising one
  assign src_level = pin_level ^ st.option[BIT_CNT_EDGE];
  assign instr_tick = (st.phase == PHASE_Q4);
  assign src_event = counter_mode ? (src_level & ~st.src_prev) : instr_tick;
  // prescaler feeds from the watchdog or the timer source, never both
  assign ps_event = to_wdt ? i_wdt_event : (src_event & ~i_sleep);
  assign ps_mask = 8'((8'h01 << rate) - 8'h01);
  assign wdt_tick_c = to_wdt & i_wdt_event & ((st.prescale & ps_mask) == ps_mask);
  // watchdog-assigned: timer sees the raw source
  assign samp_in = to_wdt ? src_level : st.prescale[rate];
  assign samp_phase = (st.phase == PHASE_Q2) || (st.phase == PHASE_Q4);
  assign samp_rise = samp_phase & samp_in & ~st.ps_sample;
  assign inc_req = (counter_mode | ~to_wdt) ? samp_rise : instr_tick;
  assign inc = inc_req & ~i_sleep & (st.inhibit == 4'h0);
  assign ovf_ev = inc & (st.count == 8'hFF);

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  assign setup = i_apb.psel & ~i_apb.penable;
  assign access = i_apb.psel & i_apb.penable & st.rsp.pready;
  assign idx = i_apb.paddr[9:2];
  assign aligned = (i_apb.paddr[ADDR_W-1:10] == '0) && (i_apb.paddr[1:0] == 2'h0);
  assign wr = access & i_apb.pwrite & ~st.rsp.pslverr;
  assign wr_timer = wr & (idx == IDX_TIMER_COUNT);
  assign wr_intcon = wr & (idx == IDX_INT_CONTROL);
  assign events = {wdt_tick_c, ovf_ev};

  always_comb begin
    rd_hit = aligned;
    rd_data = 8'h00;
    case (idx)
      IDX_TIMER_COUNT: rd_data = st.count;
      IDX_INT_CONTROL: rd_data = st.intcon;
      IDX_OPTION: rd_data = st.option;
      IDX_IRQ_STATUS: rd_data = 8'(st.status);
      IDX_IRQ_MASK: rd_data = 8'(st.mask);
      default: rd_hit = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    nx = st;
    nx.phase = st.phase + 2'h1;
    nx.pin_meta = i_ext_count_pin;
    nx.pin_sync = st.pin_meta;
    nx.src_prev = src_level;
    if (samp_phase) begin
      nx.ps_sample = samp_in;
    end
    if (ps_event) begin
      nx.prescale = st.prescale + 8'h01;
    end
    // prescaler content is lost when it is cleared; software has no view of it
    if ((i_wdt_clear & to_wdt) | (wr_timer & ~to_wdt)) begin
      nx.prescale = 8'h00;
    end
    if (st.inhibit != 4'h0) begin
      nx.inhibit = st.inhibit - 4'h1;
    end
    if (inc) begin
      nx.count = st.count + 8'h01;
    end
    if (wr_timer) begin
      nx.count = i_apb.pwdata[7:0];
      nx.inhibit = INHIBIT_CLKS;
    end
    if (wr_intcon) begin
      nx.intcon = i_apb.pwdata[7:0];
    end
    // set wins over a software clear in the same cycle
    if (ovf_ev) begin
      nx.intcon[BIT_OVF_FLAG] = 1'b1;
    end
    if (wr & (idx == IDX_OPTION)) begin
      nx.option = i_apb.pwdata[7:0];
    end
    if (wr & (idx == IDX_IRQ_MASK)) begin
      nx.mask = i_apb.pwdata[NUM_EVENTS-1:0];
    end
    if (wr & (idx == IDX_IRQ_STATUS)) begin
      nx.status = (st.status & ~i_apb.pwdata[NUM_EVENTS-1:0]) | events;
    end else begin
      nx.status = st.status | events;
    end
    nx.rsp.pready = setup;
    nx.rsp.pslverr = setup & ~rd_hit;
    nx.rsp.prdata = (setup & rd_hit) ? {24'h000000, rd_data} : 32'h00000000;
    nx.timer_int = st.intcon[BIT_OVF_EN] & st.intcon[BIT_OVF_FLAG];
    nx.irq = |(st.status & st.mask);
    nx.wdt_tick = wdt_tick_c;
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      st <= '0;
      st.option <= OPTION_RESET;
      st.intcon <= INTCON_RESET;
    end else begin
      st <= nx;
    end
  end

  assign o_apb = st.rsp;
  assign o_wdt_tick = st.wdt_tick;
  assign o_timer_int = st.timer_int;
  assign o_irq = st.irq;
  assign o_port_pullup_disable = st.option[BIT_PULLUP_DIS];
  assign o_ext_int_edge_rising = st.option[BIT_INT_EDGE];

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_reset_n);

  option_reset_a: assert property (
    disable iff (1'b0) !i_reset_n |=> st.option == 8'hFF)
    else $error("option register not all ones after reset");

  inhibit_hold_a: assert property (
    wr_timer |=> (st.count == $past(i_apb.pwdata[7:0])) ##1 $stable(st.count) [*7])
    else $error("counter moved within two instruction cycles of a write");

  overflow_set_a: assert property (
    (inc && !wr_timer && st.count == 8'hFF) |=> (st.count == 8'h00 && st.intcon[2]))
    else $error("rollover did not set the overflow flag");

  flag_sticky_a: assert property (
    (st.intcon[2] && !wr_intcon) |=> st.intcon[2])
    else $error("overflow flag cleared without a software write");

  int_enable_a: assert property (
    (!st.intcon[5]) |=> !o_timer_int)
    else $error("timer interrupt raised while disabled");

  sleep_stop_a: assert property (
    (i_sleep && !wr_timer) |=> $stable(st.count))
    else $error("timer counted during sleep");

  sample_phase_a: assert property (
    (inc && counter_mode) |-> (st.phase == 2'h1 || st.phase == 2'h3))
    else $error("counter-mode increment outside sampling phases");

  ps_write_clear_a: assert property (
    (wr_timer && !to_wdt) |=> st.prescale == 8'h00)
    else $error("counter write did not clear the prescaler");

  wdt_clear_a: assert property (
    (i_wdt_clear && to_wdt) |=> st.prescale == 8'h00)
    else $error("watchdog clear did not clear the prescaler");

  timer_rate_a: assert property (
    (!counter_mode && to_wdt && !i_sleep && st.inhibit == 4'h0 && st.phase == 2'h3
     && !wr_timer) |=> st.count == 8'($past(st.count) + 8'h01))
    else $error("timer mode missed an instruction-cycle increment");

  analog_zero_a: assert property (
    (i_analog_select && counter_mode && to_wdt && !st.option[4]
     && $past(i_analog_select) && !wr_timer) |=> $stable(st.count))
    else $error("analog-selected pin still counted");

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  reset_count_a: assert property (
    disable iff (1'b0) !i_reset_n |=> st.count == 8'h00)
    else $error("counter not cleared by reset");

  reset_intcon_a: assert property (
    disable iff (1'b0) !i_reset_n |=> st.intcon == 8'h00)
    else $error("interrupt control not cleared by reset");

  reset_ready_a: assert property (
    disable iff (1'b0) !i_reset_n |=> !o_apb.pready)
    else $error("bus ready high after reset");

  reset_status_a: assert property (
    disable iff (1'b0) !i_reset_n |=> st.status == '0)
    else $error("event status not cleared by reset");

  ////////////////////////////////////////////////////////////////////////////
  // register bus
  ready_follows_a: assert property (
    setup |=> o_apb.pready)
    else $error("setup phase not answered with ready");

  ready_only_a: assert property (
    !setup |=> !o_apb.pready)
    else $error("ready raised without a setup phase");

  slverr_unmapped_a: assert property (
    (setup && !rd_hit) |=> o_apb.pslverr)
    else $error("unmapped access not flagged as error");

  unaligned_err_a: assert property (
    (setup && i_apb.paddr[1:0] != 2'h0) |=> o_apb.pslverr)
    else $error("unaligned access not flagged as error");

  rdata_err_a: assert property (
    o_apb.pslverr |-> o_apb.prdata == 32'h00000000)
    else $error("error response carried data");

  rdata_high_a: assert property (
    o_apb.pready |-> o_apb.prdata[31:8] == 24'h000000)
    else $error("unused read data bits not zero");

  read_count_a: assert property (
    (setup && aligned && idx == IDX_TIMER_COUNT) |=> o_apb.prdata[7:0] == $past(st.count))
    else $error("counter read returned a stale value");

  option_write_a: assert property (
    (wr && idx == IDX_OPTION) |=> st.option == $past(i_apb.pwdata[7:0]))
    else $error("option write not stored");

  intcon_write_a: assert property (
    (wr_intcon && !ovf_ev) |=> st.intcon == $past(i_apb.pwdata[7:0]))
    else $error("interrupt control write not stored");

  flag_clear_a: assert property (
    (wr_intcon && !i_apb.pwdata[2] && !ovf_ev) |=> !st.intcon[2])
    else $error("software clear of the overflow flag lost");

  mask_write_a: assert property (
    (wr && idx == IDX_IRQ_MASK) |=> st.mask == $past(i_apb.pwdata[NUM_EVENTS-1:0]))
    else $error("mask write not stored");

  pullup_out_a: assert property (
    (wr && idx == IDX_OPTION) |=> o_port_pullup_disable == $past(i_apb.pwdata[7]))
    else $error("pull-up disable output does not follow option");

  int_edge_out_a: assert property (
    (wr && idx == IDX_OPTION) |=> o_ext_int_edge_rising == $past(i_apb.pwdata[6]))
    else $error("interrupt edge output does not follow option");

  ////////////////////////////////////////////////////////////////////////////
  // counting and prescaler
  inhibit_load_a: assert property (
    wr_timer |=> st.inhibit == INHIBIT_CLKS)
    else $error("counter write did not load the inhibit span");

  inhibit_end_a: assert property (
    (st.inhibit == 4'h1 && !wr_timer) |=> st.inhibit == 4'h0)
    else $error("inhibit span did not end");

  no_inc_inhibit_a: assert property (
    (st.inhibit != 4'h0) |-> !inc)
    else $error("increment inside inhibit span");

  step_one_a: assert property (
    (inc && !wr_timer) |=> st.count == 8'($past(st.count) + 8'h01))
    else $error("counter did not step by one");

  no_skip_a: assert property (
    (!inc && !wr_timer) |=> $stable(st.count))
    else $error("counter moved without an increment");

  counter_src_a: assert property (
    (counter_mode && !samp_rise) |-> !inc)
    else $error("counter mode counted without a sampled edge");

  phase_step_a: assert property (
    1'b1 |=> st.phase == 2'($past(st.phase) + 2'h1))
    else $error("phase counter skipped");

  sample_hold_a: assert property (
    !samp_phase |=> $stable(st.ps_sample))
    else $error("source sampled outside its phases");

  ps_count_a: assert property (
    (ps_event && !(i_wdt_clear && to_wdt) && !(wr_timer && !to_wdt))
     |=> st.prescale == 8'($past(st.prescale) + 8'h01))
    else $error("prescaler missed a source event");

  ps_wdt_idle_a: assert property (
    (to_wdt && !i_wdt_event && !i_wdt_clear) |=> $stable(st.prescale))
    else $error("watchdog-assigned prescaler moved without a tick");

  ps_sleep_a: assert property (
    (!to_wdt && i_sleep && !wr_timer) |=> $stable(st.prescale))
    else $error("timer-assigned prescaler ran during sleep");

  wdt_clear_only_a: assert property (
    (i_wdt_clear && !to_wdt && !wr_timer && !ps_event) |=> $stable(st.prescale))
    else $error("watchdog clear touched the timer prescaler");

  wdt_one_one_a: assert property (
    (to_wdt && rate == 3'h0 && i_wdt_event) |=> o_wdt_tick)
    else $error("watchdog 1:1 rate dropped a tick");

  wdt_no_tick_a: assert property (
    !to_wdt |=> !o_wdt_tick)
    else $error("watchdog tick while prescaler serves the timer");

  wdt_tick_out_a: assert property (
    wdt_tick_c |=> o_wdt_tick)
    else $error("divided watchdog tick not passed out");

  ////////////////////////////////////////////////////////////////////////////
  // flags and interrupts
  timer_int_on_a: assert property (
    (st.intcon[5] && st.intcon[2]) |=> o_timer_int)
    else $error("enabled overflow did not raise the interrupt");

  status_sticky_a: assert property (
    (st.status[0] && !(wr && idx == IDX_IRQ_STATUS)) |=> st.status[0])
    else $error("overflow status lost without a clear");

  status_set_a: assert property (
    ovf_ev |=> st.status[0])
    else $error("overflow did not set its status bit");

  wdt_status_a: assert property (
    wdt_tick_c |=> st.status[1])
    else $error("watchdog tick did not set its status bit");

  irq_on_a: assert property (
    (|(st.status & st.mask)) |=> o_irq)
    else $error("unmasked event did not raise the interrupt");

  irq_off_a: assert property (
    !(|(st.status & st.mask)) |=> !o_irq)
    else $error("interrupt high with no unmasked event");
endmodule : timer8

// *** sim/count_pin_model.sv ***
// model of the source that drives the external count pin
`timescale 1ns/1ps
module count_pin_model (
  input wire logic i_clk_sys,
  input wire logic i_toggle,
  output logic o_pin
);
  initial o_pin = 1'b0;
  // one level change per request; caller keeps each level for many clocks
  always @(posedge i_clk_sys) begin
    if (i_toggle) begin
      o_pin <= ~o_pin;
    end
  end
endmodule : count_pin_model

// *** sim/timer8_tb.sv ***
// self-checking bench of the 8-bit timer
`timescale 1ns/1ps
module timer8_tb;
  import timer8_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  apb_req_type req = '0;
  apb_rsp_type rsp;
  logic tog = 1'b0;
  logic pin;
  logic ana = 1'b0;
  logic slp = 1'b0;
  logic wev = 1'b0;
  logic wclr = 1'b0;
  logic wtick, tint, irq, pud, edr, err;
  int num_errors = 0;
  int checked = 0;
  int ticks = 0;
  logic [7:0] q, a;
  always #5 clk = ~clk;
  always @(negedge clk) begin
    if (wtick === 1'b1) begin
      ticks++;
    end
  end
  count_pin_model count_pin_model_i (.i_clk_sys(clk), .i_toggle(tog), .o_pin(pin));
  timer8 timer8_i (.i_clk_sys(clk), .i_reset_n(rst_n), .i_apb(req), .o_apb(rsp),
    .i_ext_count_pin(pin), .i_analog_select(ana), .i_sleep(slp), .i_wdt_event(wev),
    .i_wdt_clear(wclr), .o_wdt_tick(wtick), .o_timer_int(tint), .o_irq(irq),
    .o_port_pullup_disable(pud), .o_ext_int_edge_rising(edr));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{1'b1, 1'b0, w, ADDR_W'({idx, 2'b00}), 32'(d)};
    @(posedge clk);
    req.penable <= 1'b1;
    // ready looked at mid-cycle, ahead of the edge that samples it
    do begin
      @(negedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    q = rsp.prdata[7:0];
    err = rsp.pslverr;
    if (n >= 50) begin
      num_errors++;
    end
    @(posedge clk);
    req <= '0;
  endtask : apb
  // read spacing is gap + 3 clocks
  task automatic delta(input int gap, output logic [7:0] d);
    apb(1'b0, IDX_TIMER_COUNT, 8'h00);
    a = q;
    repeat (gap) @(posedge clk);
    apb(1'b0, IDX_TIMER_COUNT, 8'h00);
    d = q - a;
  endtask : delta
  task automatic wclear;
    wclr <= 1'b1;
    @(posedge clk);
    wclr <= 1'b0;
  endtask : wclear
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_reset;
    apb(1'b0, IDX_OPTION, 8'h00);
    chk("option", q, 8'hFF);
    apb(1'b0, IDX_INT_CONTROL, 8'h00);
    chk("intcon", q, 8'h00);
    chk("pullup", 8'(pud), 8'h01);
    chk("edge", 8'(edr), 8'h01);
    apb(1'b0, 8'h40, 8'h00);
    chk("unmapped", 8'(err), 8'h01);
  endtask : test_reset
  task automatic test_timer;
    logic [7:0] d;
    wclear();
    apb(1'b1, IDX_OPTION, 8'h08);
    repeat (2) @(posedge clk);
    chk("pullup", 8'(pud), 8'h00);
    chk("edge", 8'(edr), 8'h00);
    delta(37, d);
    chk("tmr rate", d, 8'h0A);
    apb(1'b1, IDX_TIMER_COUNT, 8'h00);
    repeat (4) @(posedge clk);
    apb(1'b0, IDX_TIMER_COUNT, 8'h00);
    chk("inhibit", q, 8'h00);
    slp <= 1'b1;
    delta(37, d);
    chk("sleep", d, 8'h00);
    slp <= 1'b0;
  endtask : test_timer
  task automatic test_overflow;
    apb(1'b1, IDX_TIMER_COUNT, 8'hFE);
    repeat (40) @(posedge clk);
    apb(1'b0, IDX_INT_CONTROL, 8'h00);
    chk("flag", q, 8'h04);
    chk("int off", 8'(tint), 8'h00);
    apb(1'b1, IDX_INT_CONTROL, 8'h24);
    repeat (2) @(posedge clk);
    chk("int on", 8'(tint), 8'h01);
    apb(1'b0, IDX_IRQ_STATUS, 8'h00);
    chk("status", q, 8'h01);
    chk("masked", 8'(irq), 8'h00);
    apb(1'b1, IDX_IRQ_MASK, 8'h01);
    repeat (2) @(posedge clk);
    chk("irq", 8'(irq), 8'h01);
    apb(1'b1, IDX_IRQ_STATUS, 8'h01);
    repeat (2) @(posedge clk);
    chk("irq clr", 8'(irq), 8'h00);
    apb(1'b0, IDX_INT_CONTROL, 8'h00);
    chk("sticky", q, 8'h24);
    apb(1'b1, IDX_INT_CONTROL, 8'h20);
    repeat (2) @(posedge clk);
    chk("int clr", 8'(tint), 8'h00);
  endtask : test_overflow
  task automatic test_prescale;
    logic [7:0] d;
    apb(1'b1, IDX_OPTION, 8'h00);
    delta(77, d);
    chk("ps 1:2", d, 8'h0A);
    apb(1'b1, IDX_OPTION, 8'h07);
    delta(1021, d);
    chk("ps 1:256", d, 8'h01);
  endtask : test_prescale
  task automatic pin_step(input logic [7:0] opt, input logic [7:0] exp);
    apb(1'b1, IDX_OPTION, opt);
    repeat (20) @(posedge clk);
    apb(1'b0, IDX_TIMER_COUNT, 8'h00);
    a = q;
    tog <= 1'b1;
    @(posedge clk);
    tog <= 1'b0;
    repeat (30) @(posedge clk);
    apb(1'b0, IDX_TIMER_COUNT, 8'h00);
    chk("pin count", q - a, exp);
  endtask : pin_step
  task automatic test_counter;
    wclear();
    apb(1'b1, IDX_TIMER_COUNT, 8'h00);
    pin_step(8'h28, 8'h01);
    pin_step(8'h38, 8'h01);
    pin_step(8'h38, 8'h00);
    ana <= 1'b1;
    pin_step(8'h38, 8'h00);
  endtask : test_counter
  task automatic test_wdt;
    apb(1'b1, IDX_OPTION, 8'h29);
    wclear();
    ticks = 0;
    repeat (4) begin
      wev <= 1'b1;
      @(posedge clk);
      wev <= 1'b0;
      repeat (3) @(posedge clk);
    end
    chk("wdt ticks", 8'(ticks), 8'h02);
    apb(1'b0, IDX_IRQ_STATUS, 8'h00);
    chk("wdt status", q & 8'h02, 8'h02);
  endtask : test_wdt
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    if (num_errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    test_reset();
    test_timer();
    test_overflow();
    test_prescale();
    test_counter();
    test_wdt();
    tally_and_finish();
  end
  initial begin
    #100000;
    num_errors++;
    tally_and_finish();
  end
endmodule : timer8_tb
